/* verilog/dmam_defines.svh */
`ifndef DMAM_DEFINES_SVH
`define DMAM_DEFINES_SVH

// System register offsets (7-bit data memory address)
`define DMAM_ADDR_IXH   7'h7A
`define DMAM_ADDR_IXM   7'h7B
`define DMAM_ADDR_IXL   7'h7C
`define DMAM_ADDR_RPH   7'h7D
`define DMAM_ADDR_RPL   7'h7E
`define DMAM_ADDR_PSW   7'h7F

// Field positions
`define DMAM_BIT_RPON   3
`define DMAM_BIT_DEC    0
`define DMAM_BIT_CMP    3
`define DMAM_BIT_CY     2
`define DMAM_BIT_Z      1
`define DMAM_BIT_IXE    0

// Reset values
`define DMAM_RST_NIB    4'h0
`define DMAM_RST_IDX    11'h000
`define DMAM_RST_ADDR   11'h000
`define DMAM_RST_RPL    3'h0

// Decimal arithmetic limits
`define DMAM_BCD_MAX    5'h09
`define DMAM_BCD_ADJ    5'h06

`endif

/* verilog/dmam_pkg.sv */
package dmam_pkg;

  // Decoded instruction class handed over by the decoder
  typedef enum logic [3:0] {
    OP_ADD    = 4'h0,
    OP_ADDC   = 4'h1,
    OP_SUB    = 4'h2,
    OP_SUBC   = 4'h3,
    OP_AND    = 4'h4,
    OP_OR     = 4'h5,
    OP_XOR    = 4'h6,
    OP_MOV    = 4'h7,
    OP_ST_IND = 4'h8,
    OP_LD_IND = 4'h9,
    OP_SKT    = 4'hA,
    OP_SKF    = 4'hB,
    OP_ROTATE_RIGHT_THRU_CARRY   = 4'hC,
    OP_FIXED  = 4'hD
  } op_t;

  // Whole state of the address modifier
  typedef struct packed {
    logic        rp_on;
    logic [10:0] idx;
    logic [2:0]  rp_low;
    logic        dec;
    logic        cmp;
    logic        cy;
    logic        z;
    logic        ix_on;
    logic [3:0]  rdata;
    logic [10:0] dir_addr;
    logic [10:0] ind_addr;
    logic [10:0] gen_addr;
    logic [3:0]  result;
    logic        wr_en;
    logic        skip;
    logic        done;
  } state_t;

endpackage

/* verilog/alu_nibble.sv */
`timescale 1ns/1ps
`include "dmam_defines.svh"

module alu_nibble (
  // Operands
  input  wire logic [3:0] i_a,
  input  wire logic [3:0] i_b,
  input  wire logic       i_cin,
  // Mode
  input  wire logic       i_sub,
  input  wire logic       i_dec,
  // Result
  output logic      [3:0] o_sum,
  output logic            o_cout
);

  logic [4:0] bin;

  // Binary result first, decimal adjust on top of it
  always_comb begin
    if (i_sub) begin
      bin = {1'b0, i_a} - {1'b0, i_b} - {4'h0, i_cin};
    end else begin
      bin = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_cin};
    end
    o_sum  = bin[3:0];
    o_cout = bin[4];
    if (i_dec) begin
      if (!i_sub) begin
        // Sums above nine wrap into the next decade
        o_cout = (bin > `DMAM_BCD_MAX);
        if (o_cout) begin
          o_sum = 4'(bin + `DMAM_BCD_ADJ);
        end
      end else if (bin[4]) begin
        o_sum = 4'(bin - `DMAM_BCD_ADJ);
      end
    end
  end

endmodule

/* verilog/data_memory_address_modifier.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "dmam_defines.svh"

module data_memory_address_modifier (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Decoded instruction
  input  wire logic        i_op_valid,
  input  wire logic [3:0]  i_op,
  input  wire logic [3:0]  i_bank,
  input  wire logic [6:0]  i_m_addr,
  input  wire logic [3:0]  i_r_col,
  input  wire logic [3:0]  i_r_data,
  input  wire logic [3:0]  i_opnd,
  // Register port
  input  wire logic [6:0]  i_reg_addr,
  input  wire logic [3:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [3:0]  o_reg_rdata,
  // Addresses and datapath results
  output logic      [10:0] o_dir_addr,
  output logic      [10:0] o_ind_addr,
  output logic      [10:0] o_gen_addr,
  output logic      [3:0]  o_result,
  output logic             o_wr_en,
  output logic             o_skip,
  output logic             o_done,
  // Flags
  output logic             o_row_pointer_on,
  output logic             o_index_on,
  output logic             o_decimal_mode,
  output logic             o_compare_mode,
  output logic             o_carry,
  output logic             o_zero
);

  //--------------------------------------------------------------
  // Decode helpers
  //--------------------------------------------------------------

  function automatic logic is_arith(input logic [3:0] op);
    is_arith = (op <= 4'(dmam_pkg::OP_SUBC));
  endfunction

  function automatic logic is_indirect(input logic [3:0] op);
    is_indirect = (op == 4'(dmam_pkg::OP_ST_IND)) ||
                  (op == 4'(dmam_pkg::OP_LD_IND));
  endfunction

  // Ops whose direct operand may be index-modified
  function automatic logic is_indexable(input logic [3:0] op);
    is_indexable = (op != 4'(dmam_pkg::OP_ROTATE_RIGHT_THRU_CARRY)) &&
                   (op != 4'(dmam_pkg::OP_FIXED));
  endfunction

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------

  dmam_pkg::state_t st_q;
  dmam_pkg::state_t st_d;

  logic [10:0] raw_addr;
  logic [6:0]  raw_row;
  logic [6:0]  row_ptr;
  logic        r_lsb;
  logic [10:0] real_addr;
  logic        use_index;
  logic        alu_sub;
  logic        alu_cin;
  logic [3:0]  alu_sum;
  logic        alu_cout;
  logic [3:0]  rd_mux;

  // Unmodified address and the pointer view of the index register
  assign raw_addr = {i_bank, i_m_addr};
  assign raw_row  = raw_addr[10:4];
  assign row_ptr  = st_q.idx[10:4];
  assign r_lsb    = i_r_data[0];

  // Status word access stays unmodified so indexing can be turned off
  assign use_index = st_q.ix_on && is_indexable(i_op) &&
                     (i_m_addr != `DMAM_ADDR_PSW);
  assign real_addr = use_index ? (raw_addr | st_q.idx)
                               : raw_addr;

  // Carry chains only for the carry-using variants
  assign alu_sub = (i_op == 4'(dmam_pkg::OP_SUB)) ||
                   (i_op == 4'(dmam_pkg::OP_SUBC));
  assign alu_cin = st_q.cy && ((i_op == 4'(dmam_pkg::OP_ADDC)) ||
                               (i_op == 4'(dmam_pkg::OP_SUBC)));

  alu_nibble u_alu (
    .i_a    (i_r_data),
    .i_b    (i_opnd),
    .i_cin  (alu_cin),
    .i_sub  (alu_sub),
    .i_dec  (st_q.dec),
    .o_sum  (alu_sum),
    .o_cout (alu_cout)
  );

  //--------------------------------------------------------------
  // Register read mux
  //--------------------------------------------------------------

  // Fixed upper pointer bits and unmapped offsets read as zero
  always_comb begin
    unique case (i_reg_addr)
      `DMAM_ADDR_IXH: rd_mux = {st_q.rp_on, st_q.idx[10:8]};
      `DMAM_ADDR_IXM: rd_mux = st_q.idx[7:4];
      `DMAM_ADDR_IXL: rd_mux = st_q.idx[3:0];
      `DMAM_ADDR_RPL: rd_mux = {st_q.rp_low, st_q.dec};
      `DMAM_ADDR_PSW: rd_mux = {st_q.cmp, st_q.cy,
                                st_q.z, st_q.ix_on};
      default:        rd_mux = `DMAM_RST_NIB;
    endcase
  end

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------

  // Software writes first, instruction flag updates override them
  // so a flag event in the same cycle as a write is never lost.
  always_comb begin
    st_d       = st_q;
    st_d.done  = 1'b0;
    st_d.rdata = i_reg_rd ? rd_mux : `DMAM_RST_NIB;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `DMAM_ADDR_IXH: begin
          st_d.rp_on       = i_reg_wdata[`DMAM_BIT_RPON];
          st_d.idx[10:8]   = i_reg_wdata[2:0];
        end
        `DMAM_ADDR_IXM: st_d.idx[7:4] = i_reg_wdata;
        `DMAM_ADDR_IXL: st_d.idx[3:0] = i_reg_wdata;
        `DMAM_ADDR_RPL: begin
          st_d.rp_low = i_reg_wdata[3:1];
          st_d.dec    = i_reg_wdata[`DMAM_BIT_DEC];
        end
        `DMAM_ADDR_PSW: begin
          st_d.cmp   = i_reg_wdata[`DMAM_BIT_CMP];
          st_d.cy    = i_reg_wdata[`DMAM_BIT_CY];
          st_d.z     = i_reg_wdata[`DMAM_BIT_Z];
          st_d.ix_on = i_reg_wdata[`DMAM_BIT_IXE];
        end
        default: ;
      endcase
    end
    if (i_op_valid) begin
      st_d.done     = 1'b1;
      st_d.skip     = 1'b0;
      st_d.result   = i_opnd;
      st_d.wr_en    = 1'b1;
      st_d.dir_addr = real_addr;
      // General register row lives in bank 0
      st_d.gen_addr = {4'h0, st_q.rp_low, i_r_col};
      // Indirect side follows the direct operand's bank and row; the
      // column is the contents of register r, not its own column
      st_d.ind_addr = {real_addr[10:4], i_r_data};
      if (is_indirect(i_op) && st_q.rp_on) begin
        // Pointer supplies bank (upper) and row (low three bits)
        st_d.ind_addr = {row_ptr, i_r_data};
      end
      if (is_arith(i_op)) begin
        st_d.result = alu_sum;
        st_d.wr_en  = !st_q.cmp;
        st_d.cy     = alu_cout;
        if (alu_sum != 4'h0) begin
          st_d.z = 1'b0;
        end else if (!st_q.cmp) begin
          st_d.z = 1'b1;
        end else begin
          st_d.z = st_q.z;
        end
      end else begin
        unique case (i_op)
          4'(dmam_pkg::OP_AND): st_d.result = i_r_data & i_opnd;
          4'(dmam_pkg::OP_OR):  st_d.result = i_r_data | i_opnd;
          4'(dmam_pkg::OP_XOR): st_d.result = i_r_data ^ i_opnd;
          4'(dmam_pkg::OP_SKT): begin
            st_d.wr_en = 1'b0;
            st_d.skip  = ((i_opnd & i_r_data) == i_r_data);
            st_d.cmp   = 1'b0;
          end
          4'(dmam_pkg::OP_SKF): begin
            st_d.wr_en = 1'b0;
            st_d.skip  = ((i_opnd & i_r_data) == 4'h0);
            st_d.cmp   = 1'b0;
          end
          4'(dmam_pkg::OP_ROTATE_RIGHT_THRU_CARRY): begin
            st_d.result = {st_q.cy, i_r_data[3:1]};
            st_d.cy     = r_lsb;
          end
          4'(dmam_pkg::OP_FIXED): st_d.wr_en = 1'b0;
          default: ;
        endcase
      end
    end
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------

  // All from the state register; write enable and skip are gated with done
  assign o_reg_rdata      = st_q.rdata;
  assign o_dir_addr       = st_q.dir_addr;
  assign o_ind_addr       = st_q.ind_addr;
  assign o_gen_addr       = st_q.gen_addr;
  assign o_result         = st_q.result;
  assign o_wr_en          = st_q.wr_en & st_q.done;
  assign o_skip           = st_q.skip & st_q.done;
  assign o_done           = st_q.done;
  assign o_row_pointer_on = st_q.rp_on;
  assign o_index_on       = st_q.ix_on;
  assign o_decimal_mode   = st_q.dec;
  assign o_compare_mode   = st_q.cmp;
  assign o_carry          = st_q.cy;
  assign o_zero           = st_q.z;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  plain_addr_a: assert property (
    i_op_valid && !st_q.rp_on && !st_q.ix_on |=>
      o_dir_addr == $past(raw_addr))
    else $error("direct address modified with both enables clear");

  ind_store_a: assert property (
    i_op_valid && i_op == 4'(dmam_pkg::OP_ST_IND) && !st_q.rp_on &&
    !st_q.ix_on |=>
      o_ind_addr == {$past(raw_row), $past(i_r_data)})
    else $error("indirect store address wrong");

  ind_load_a: assert property (
    i_op_valid && i_op == 4'(dmam_pkg::OP_LD_IND) && !st_q.rp_on &&
    !st_q.ix_on |=>
      o_ind_addr == {$past(raw_row), $past(i_r_data)})
    else $error("indirect load address wrong");

  row_ptr_sub_a: assert property (
    i_op_valid && is_indirect(i_op) && st_q.rp_on |=>
      o_ind_addr[10:4] == $past(row_ptr))
    else $error("row pointer not used for indirect side");

  index_or_a: assert property (
    i_op_valid && use_index |=>
      o_dir_addr == ($past(raw_addr) | $past(st_q.idx)))
    else $error("index OR not applied");

  psw_exempt_a: assert property (
    i_op_valid && i_m_addr == `DMAM_ADDR_PSW |=>
      o_dir_addr == $past(raw_addr))
    else $error("status word access was indexed");

  cmp_nowrite_a: assert property (
    i_op_valid && is_arith(i_op) && st_q.cmp |=> o_done && !o_wr_en)
    else $error("write-back not suppressed in compare mode");

  skip_clear_a: assert property (
    i_op_valid && (i_op == 4'(dmam_pkg::OP_SKT) ||
                   i_op == 4'(dmam_pkg::OP_SKF)) |=> !o_compare_mode)
    else $error("compare flag not cleared by skip test");

  rotate_right_thru_carry_carry_a: assert property (
    i_op_valid && i_op == 4'(dmam_pkg::OP_ROTATE_RIGHT_THRU_CARRY) |=>
      o_carry == $past(r_lsb))
    else $error("rotate did not load carry from lsb");

  zero_accum_a: assert property (
    i_op_valid && is_arith(i_op) && st_q.cmp && !st_q.z |=> !o_zero)
    else $error("zero flag set without prior zero in compare mode");

  fixed_op_a: assert property (
    i_op_valid && i_op == 4'(dmam_pkg::OP_FIXED) |=>
      o_dir_addr == $past(raw_addr))
    else $error("unmodifiable instruction was indexed");

endmodule

/* tb/insn_issuer.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Decoder model: hands one op per call
// ----------------------------------------
module insn_issuer (
  // Clock
  input  wire logic        i_sys_clk,
  // Decoded instruction toward the block
  output logic             o_op_valid,
  output logic      [3:0]  o_op,
  output logic      [3:0]  o_bank,
  output logic      [6:0]  o_m_addr,
  output logic      [3:0]  o_r_col,
  output logic      [3:0]  o_r_data,
  output logic      [3:0]  o_opnd
);
  // Idle at time zero, valid low
  initial begin
    o_op_valid = 1'b0;
    {o_op, o_bank, o_m_addr, o_r_col, o_r_data, o_opnd} = '0;
  end

  // One-cycle valid; fields are inverted once released, so a block that
  // samples them late sees garbage rather than the old op
  task automatic issue(input logic [3:0] op, input logic [3:0] bank,
                       input logic [6:0] m, input logic [3:0] rc,
                       input logic [3:0] rd, input logic [3:0] od);
    @(posedge i_sys_clk);
    o_op_valid <= 1'b1;
    {o_op, o_bank, o_m_addr, o_r_col, o_r_data, o_opnd} <=
      {op, bank, m, rc, rd, od};
    @(posedge i_sys_clk);
    o_op_valid <= 1'b0;
    {o_op, o_bank, o_m_addr, o_r_col, o_r_data, o_opnd} <=
      ~{op, bank, m, rc, rd, od};
  endtask
endmodule

/* tb/data_memory_address_modifier_tb.sv */
`timescale 1ns/1ps

module data_memory_address_modifier_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        i_sys_clk, i_rst, i_op_valid, i_reg_wr, i_reg_rd;
  logic [3:0]  i_op, i_bank, i_r_col, i_r_data, i_opnd, i_reg_wdata;
  logic [6:0]  i_m_addr, i_reg_addr;
  logic [3:0]  o_reg_rdata, o_result;
  logic [10:0] o_dir_addr, o_ind_addr, o_gen_addr;
  logic        o_wr_en, o_skip, o_done, o_row_pointer_on, o_index_on;
  logic        o_decimal_mode, o_compare_mode, o_carry, o_zero;
  int          miscompares, n_checks;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  insn_issuer u_insn_issuer (.i_sys_clk(i_sys_clk), .o_op_valid(i_op_valid),
    .o_op(i_op), .o_bank(i_bank), .o_m_addr(i_m_addr), .o_r_col(i_r_col),
    .o_r_data(i_r_data), .o_opnd(i_opnd));

  data_memory_address_modifier u_data_memory_address_modifier (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_bank(i_bank), .i_m_addr(i_m_addr), .i_r_col(i_r_col),
    .i_r_data(i_r_data), .i_opnd(i_opnd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_dir_addr(o_dir_addr),
    .o_ind_addr(o_ind_addr), .o_gen_addr(o_gen_addr), .o_result(o_result),
    .o_wr_en(o_wr_en), .o_skip(o_skip), .o_done(o_done),
    .o_row_pointer_on(o_row_pointer_on), .o_index_on(o_index_on),
    .o_decimal_mode(o_decimal_mode), .o_compare_mode(o_compare_mode),
    .o_carry(o_carry), .o_zero(o_zero));

  // 250 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [10:0] exp,
                     input logic [10:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wreg(input logic [6:0] a, input logic [3:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
    // Let the written value settle before any caller looks at it
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [6:0] a, input logic [3:0] exp);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 chk("reg_rdata", {7'h00, exp}, {7'h00, o_reg_rdata});
  endtask

  // Issue one op and look at the done cycle
  task automatic op(input logic [3:0] c, input logic [3:0] b,
    input logic [6:0] m, input logic [3:0] rc, input logic [3:0] rd,
    input logic [3:0] od);
    u_insn_issuer.issue(c, b, m, rc, rd, od);
    #1 chk("done", 11'h001, {10'h000, o_done});
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset();
    rreg(7'h7E, 4'h0);
    rreg(7'h7F, 4'h0);
    wreg(7'h7D, 4'hF);
    rreg(7'h7D, 4'h0);
  endtask

  task automatic s_plain();
    op(dmam_pkg::OP_ST_IND, 4'h1, 7'h34, 4'h5, 4'h8, 4'h0);
    chk("ind_st", 11'h0B8, o_ind_addr);
    chk("dir_st", 11'h0B4, o_dir_addr);
    op(dmam_pkg::OP_LD_IND, 4'h1, 7'h34, 4'hB, 4'hE, 4'h0);
    chk("ind_ld", 11'h0BE, o_ind_addr);
  endtask

  task automatic s_rowptr();
    wreg(7'h7B, 4'h5);
    wreg(7'h7A, 4'h8);
    chk("rp_on", 11'h001, {10'h000, o_row_pointer_on});
    op(dmam_pkg::OP_ST_IND, 4'h1, 7'h34, 4'h5, 4'h8, 4'h0);
    chk("ind_rp", 11'h058, o_ind_addr);
    chk("dir_rp", 11'h0B4, o_dir_addr);
    op(dmam_pkg::OP_LD_IND, 4'h1, 7'h34, 4'hB, 4'hE, 4'h0);
    chk("ind_rp_ld", 11'h05E, o_ind_addr);
    wreg(7'h7A, 4'h0);
  endtask

  // Index 152H; the status word itself must stay reachable
  task automatic s_index();
    wreg(7'h7A, 4'h1);
    wreg(7'h7C, 4'h2);
    wreg(7'h7F, 4'h1);
    rreg(7'h7A, 4'h1);
    rreg(7'h7B, 4'h5);
    rreg(7'h7C, 4'h2);
    chk("ix_on", 11'h001, {10'h000, o_index_on});
    op(dmam_pkg::OP_ADD, 4'h0, 7'h11, 4'h3, 4'h1, 4'h1);
    chk("dir_ix", 11'h153, o_dir_addr);
    op(dmam_pkg::OP_OR, 4'h0, 7'h7F, 4'h3, 4'h1, 4'h1);
    chk("dir_psw", 11'h07F, o_dir_addr);
    wreg(7'h7A, 4'h9);
    op(dmam_pkg::OP_ST_IND, 4'h0, 7'h34, 4'h5, 4'h8, 4'h0);
    chk("dir_both", 11'h176, o_dir_addr);
    chk("ind_both", 11'h158, o_ind_addr);
    wreg(7'h7F, 4'h0);
    wreg(7'h7A, 4'h0);
    chk("ix_off", 11'h000, {10'h000, o_index_on});
  endtask

  task automatic s_genreg_dec();
    wreg(7'h7E, 4'hB);
    rreg(7'h7E, 4'hB);
    chk("dec_on", 11'h001, {10'h000, o_decimal_mode});
    op(dmam_pkg::OP_ADD, 4'h0, 7'h11, 4'h3, 4'h5, 4'h7);
    chk("gen_addr", 11'h053, o_gen_addr);
    chk("bcd_sum", 11'h002, {7'h00, o_result});
    chk("bcd_cy", 11'h001, {10'h000, o_carry});
    wreg(7'h7E, 4'h0);
    op(dmam_pkg::OP_ADD, 4'h0, 7'h11, 4'h3, 4'h5, 4'h7);
    chk("bin_sum", 11'h00C, {7'h00, o_result});
  endtask

  task automatic s_flags();
    op(dmam_pkg::OP_ADD, 4'h0, 7'h11, 4'h3, 4'h9, 4'h7);
    chk("add_cz", 11'h003, {9'h000, o_carry, o_zero});
    chk("add_wr", 11'h001, {10'h000, o_wr_en});
    op(dmam_pkg::OP_SUB, 4'h0, 7'h11, 4'h3, 4'h3, 4'h5);
    chk("sub_res", 11'h00E, {7'h00, o_result});
    chk("sub_cz", 11'h002, {9'h000, o_carry, o_zero});
    // Compare on, zero clear: a zero result must not set zero
    wreg(7'h7F, 4'h8);
    op(dmam_pkg::OP_SUB, 4'h0, 7'h11, 4'h3, 4'h5, 4'h5);
    chk("cmp_z0", 11'h000, {9'h000, o_zero, o_wr_en});
    wreg(7'h7F, 4'hA);
    op(dmam_pkg::OP_SUB, 4'h0, 7'h11, 4'h3, 4'h5, 4'h5);
    chk("cmp_z1", 11'h002, {9'h000, o_zero, o_wr_en});
    op(dmam_pkg::OP_ADD, 4'h0, 7'h11, 4'h3, 4'h1, 4'h0);
    chk("cmp_nz", 11'h000, {9'h000, o_zero, o_wr_en});
  endtask

  task automatic s_skip_rotate_right_thru_carry();
    op(dmam_pkg::OP_SKT, 4'h0, 7'h11, 4'h3, 4'h3, 4'hF);
    chk("skt", 11'h001, {10'h000, o_skip});
    chk("skt_cmp", 11'h000, {10'h000, o_compare_mode});
    wreg(7'h7F, 4'h8);
    op(dmam_pkg::OP_SKF, 4'h0, 7'h11, 4'h3, 4'h3, 4'hC);
    chk("skf", 11'h001, {10'h000, o_skip});
    rreg(7'h7F, 4'h0);
    op(dmam_pkg::OP_ROTATE_RIGHT_THRU_CARRY, 4'h0, 7'h11, 4'h3, 4'h3, 4'h3);
    chk("rorc1", 11'h001, {10'h000, o_carry});
    op(dmam_pkg::OP_ROTATE_RIGHT_THRU_CARRY, 4'h0, 7'h11, 4'h3, 4'h2, 4'h2);
    chk("rorc0", 11'h000, {10'h000, o_carry});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    miscompares = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 7'h00;
    i_reg_wdata = 4'h0;
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    s_reset();
    s_plain();
    s_rowptr();
    s_index();
    s_genreg_dec();
    s_flags();
    s_skip_rotate_right_thru_carry();
    summarize();
  end

  // Watchdog: the sequence needs well under 200 cycles
  initial begin
    #40000;
    miscompares++;
    summarize();
  end
endmodule
